// ==== one_time_watchdog_reset_out.sv ====
// One-time enabled supervision timer with reset-out pulse
// Functional notes
// - Disabled and idle after every reset
// - Key 1E then E1 at A6 arms
// - Fourteen-bit dedicated supervision counter
// - Armed counter advances each machine cycle
// - Software cannot disarm; only reset
// - Reaching 3FFF overflows and resets device
// - Key sequence while armed restarts count
// - Service register write-only, counter hidden
// - Overflow drives reset pin high
// - Pulse 98 or 196 oscillator periods
// - Flash bit forces six-clock, else register
// - Flash clock bit sampled at power-on
`include "watchdog_defines.svh"
module one_time_watchdog_reset_out #(
  parameter int COUNT_WIDTH = `WD_COUNT_WIDTH
) (
  input  wire logic       ref_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       clk_en_in,
  input  wire logic       power_on_in,
  input  wire logic       sfr_wr_in,
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic [7:0] sfr_wdata_in,
  input  wire logic       flash_clock_mode_bit_in,
  input  wire logic       sfr_clock_mode_bit_in,
  output logic            rst_pin_out,
  output logic            rst_pin_oe_out,
  output logic            device_reset_out,
  output logic            timer_armed_out
);
  // Elaboration check: the overflow point is fixed at a fourteen-bit top count
  if (COUNT_WIDTH != `WD_COUNT_WIDTH) begin : gen_bad_width
    $error("COUNT_WIDTH must be 14");
  end

  watchdog_pkg::key_state_t key_reg;
  logic                     armed_reg;
  logic [COUNT_WIDTH-1:0]   count_reg;
  logic                     flash_mode_reg;
  logic                     flash_sync1_reg;
  logic                     flash_sync2_reg;
  logic                     por_sync1_reg;
  logic                     por_sync2_reg;
  logic                     sfr_mode_sync1_reg;
  logic                     sfr_mode_sync2_reg;
  logic                     six_clk_mode;
  logic                     mc_tick;
  logic                     svc_wr;
  logic                     key_done;
  logic                     overflow;
  logic                     pulse;
  logic                     pulse_d_reg;

  // Pin inputs through two flip-flops
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      flash_sync1_reg    <= 1'b0;
      flash_sync2_reg    <= 1'b0;
      por_sync1_reg      <= 1'b0;
      por_sync2_reg      <= 1'b0;
      sfr_mode_sync1_reg <= 1'b0;
      sfr_mode_sync2_reg <= 1'b0;
    end else if (clk_en_in) begin
      flash_sync1_reg    <= flash_clock_mode_bit_in;
      flash_sync2_reg    <= flash_sync1_reg;
      por_sync1_reg      <= power_on_in;
      por_sync2_reg      <= por_sync1_reg;
      sfr_mode_sync1_reg <= sfr_clock_mode_bit_in;
      sfr_mode_sync2_reg <= sfr_mode_sync1_reg;
    end
  end

  // Latch at power-on
  // Flash mode bit held across ordinary resets; only power-on reloads it
  always_ff @(posedge ref_clk_in) begin
    if (clk_en_in && por_sync2_reg) begin
      flash_mode_reg <= flash_sync2_reg;
    end
  end

  assign six_clk_mode = flash_mode_reg || sfr_mode_sync2_reg;

  machine_cycle_gen u_mc (
    .ref_clk_in      (ref_clk_in),
    .sys_rst_in      (sys_rst_in || por_sync2_reg),
    .clk_en_in       (clk_en_in),
    .six_clk_mode_in (six_clk_mode),
    .mc_tick_out     (mc_tick)
  );

  // Write-only decode
  // Only writes reach the service register; there is no read path
  assign svc_wr = clk_en_in && sfr_wr_in && (sfr_addr_in == `WD_SERVICE_ADDR);
  assign key_done = svc_wr && (key_reg == watchdog_pkg::KEY_FIRST)
                    && (sfr_wdata_in == `WD_KEY_SECOND);

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || por_sync2_reg || overflow) begin
      key_reg <= watchdog_pkg::KEY_IDLE;
    end else if (svc_wr) begin
      case (key_reg)
        watchdog_pkg::KEY_IDLE: begin
          key_reg <= (sfr_wdata_in == `WD_KEY_FIRST) ? watchdog_pkg::KEY_FIRST
                                                     : watchdog_pkg::KEY_IDLE;
        end
        watchdog_pkg::KEY_FIRST: begin
          // A repeated first byte starts a new sequence
          key_reg <= (sfr_wdata_in == `WD_KEY_FIRST) ? watchdog_pkg::KEY_FIRST
                                                     : watchdog_pkg::KEY_IDLE;
        end
        default: begin
          key_reg <= watchdog_pkg::KEY_IDLE;
        end
      endcase
    end
  end

  // Arm state
  // Arms on completed key; no write can clear it, only reset or overflow
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || por_sync2_reg || device_reset_out) begin
      armed_reg <= 1'b0;
    end else if (key_done) begin
      armed_reg <= 1'b1;
    end
  end

  assign overflow = armed_reg && mc_tick && (count_reg == `WD_COUNT_TOP);

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || por_sync2_reg || device_reset_out) begin
      count_reg <= '0;
    end else if (clk_en_in) begin
      if (key_done || overflow) begin
        count_reg <= '0;
      end else if (armed_reg && mc_tick) begin
        count_reg <= count_reg + COUNT_WIDTH'(1);
      end
    end
  end

  reset_pulse_gen u_pulse (
    .ref_clk_in      (ref_clk_in),
    .sys_rst_in      (sys_rst_in || por_sync2_reg),
    .clk_en_in       (clk_en_in),
    .fire_in         (overflow),
    .six_clk_mode_in (six_clk_mode),
    .pulse_out       (pulse)
  );

  // Registered copy so outputs come from flip-flops
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pulse_d_reg <= 1'b0;
    end else if (clk_en_in) begin
      pulse_d_reg <= pulse;
    end
  end

  assign rst_pin_out      = pulse_d_reg;
  assign rst_pin_oe_out   = pulse_d_reg;
  assign device_reset_out = pulse_d_reg;
  assign timer_armed_out  = armed_reg;
endmodule

// ==== watchdog_defines.svh ====
// Constants for the one-time supervision timer
`ifndef WATCHDOG_DEFINES_SVH
`define WATCHDOG_DEFINES_SVH
`define WD_SERVICE_ADDR   8'hA6
`define WD_KEY_FIRST      8'h1E
`define WD_KEY_SECOND     8'hE1
`define WD_COUNT_WIDTH    14
`define WD_COUNT_TOP      14'h3FFF
`define WD_PULSE_OSC_6CLK 98
`define WD_PULSE_OSC_12CLK 196
`define WD_OSC_PER_MC_6   6
`define WD_OSC_PER_MC_12  12
`endif

// ==== watchdog_pkg.sv ====
// Types shared by the supervision timer files
package watchdog_pkg;
  typedef enum logic [1:0] {
    KEY_IDLE  = 2'b00,
    KEY_FIRST = 2'b01
  } key_state_t;
endpackage

// ==== machine_cycle_gen.sv ====
// Machine-cycle tick generator from oscillator clock and clock mode
`include "watchdog_defines.svh"
module machine_cycle_gen (
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic clk_en_in,
  input  wire logic six_clk_mode_in,
  output logic      mc_tick_out
);
  logic [3:0] div_reg;
  logic [3:0] div_last;

  // Last count of the divider for the current mode
  assign div_last = six_clk_mode_in ? 4'(`WD_OSC_PER_MC_6 - 1) : 4'(`WD_OSC_PER_MC_12 - 1);

  // Oscillator divider
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      div_reg <= 4'h0;
    end else if (clk_en_in) begin
      if (div_reg >= div_last) begin
        div_reg <= 4'h0;
      end else begin
        div_reg <= div_reg + 4'h1;
      end
    end
  end

  // One-cycle tick per machine cycle
  assign mc_tick_out = clk_en_in && (div_reg >= div_last);
endmodule

// ==== reset_pulse_gen.sv ====
// Fixed-length reset pulse generator in oscillator periods
`include "watchdog_defines.svh"
module reset_pulse_gen (
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic clk_en_in,
  input  wire logic fire_in,
  input  wire logic six_clk_mode_in,
  output logic      pulse_out
);
  logic [7:0] cnt_reg;

  // Load length at fire, count down while high
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cnt_reg <= 8'h00;
    end else if (clk_en_in) begin
      if (fire_in && cnt_reg == 8'h00) begin
        cnt_reg <= six_clk_mode_in ? 8'(`WD_PULSE_OSC_6CLK) : 8'(`WD_PULSE_OSC_12CLK);
      end else if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end

  assign pulse_out = (cnt_reg != 8'h00);
endmodule

// ==== one_time_watchdog_chk.sv ====
// Port checker for the supervision timer
`include "watchdog_defines.svh"
module one_time_watchdog_chk (
  input wire logic       ref_clk_in,
  input wire logic       sys_rst_in,
  input wire logic       clk_en_in,
  input wire logic       power_on_in,
  input wire logic       sfr_wr_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic       rst_pin_out,
  input wire logic       rst_pin_oe_out,
  input wire logic       device_reset_out,
  input wire logic       timer_armed_out
);
  logic [7:0] hi_len_reg;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in || power_on_in);
  // Counts cycles of the reset pulse
  always_ff @(posedge ref_clk_in) begin
    hi_len_reg <= rst_pin_out ? hi_len_reg + 8'h01 : 8'h00;
  end
  sequence s_wr(v);
    clk_en_in && sfr_wr_in && sfr_addr_in == `WD_SERVICE_ADDR && sfr_wdata_in == v;
  endsequence
  property p_idle; $fell(power_on_in) |-> !timer_armed_out && !rst_pin_out; endproperty
  property p_arm;
    s_wr(`WD_KEY_FIRST) ##1 !sfr_wr_in ##1 s_wr(`WD_KEY_SECOND) |=> timer_armed_out;
  endproperty
  property p_cause;
    $rose(timer_armed_out) |-> $past(sfr_wr_in) && $past(sfr_wdata_in) == `WD_KEY_SECOND;
  endproperty
  property p_keep; timer_armed_out && !rst_pin_out |=> timer_armed_out; endproperty
  property p_drop; $rose(rst_pin_out) |=> !timer_armed_out; endproperty
  property p_src; $rose(rst_pin_out) |-> timer_armed_out; endproperty
  property p_pins; rst_pin_out |-> rst_pin_oe_out && device_reset_out; endproperty
  property p_len; $fell(rst_pin_out) |-> hi_len_reg == 8'h62 || hi_len_reg == 8'hC4; endproperty
  a_idle: assert property (p_idle) else $error("not idle after reset");
  a_arm: assert property (p_arm) else $error("key did not arm");
  a_cause: assert property (p_cause) else $error("armed without key");
  a_keep: assert property (p_keep) else $error("disarmed by software");
  a_drop: assert property (p_drop) else $error("armed after overflow");
  a_src: assert property (p_src) else $error("pulse while unarmed");
  a_pins: assert property (p_pins) else $error("pin not driven");
  a_len: assert property (p_len) else $error("pulse length wrong");
endmodule
bind one_time_watchdog_reset_out one_time_watchdog_chk u_chk (.ref_clk_in(ref_clk_in),
  .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in), .power_on_in(power_on_in),
  .sfr_wr_in(sfr_wr_in), .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in),
  .rst_pin_out(rst_pin_out), .rst_pin_oe_out(rst_pin_oe_out),
  .device_reset_out(device_reset_out), .timer_armed_out(timer_armed_out));

// ==== one_time_watchdog_reset_out_tb.sv ====
// Self-checking bench for the supervision timer
module one_time_watchdog_reset_out_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst, en, por, wr, fx, sx, pin, oe, drst, armed, last, mon;
  logic [7:0] addr, wd;
  int         failures, cmp_count, n;
  logic       exp_q[$];
  one_time_watchdog_reset_out dut (.ref_clk_in(clk), .sys_rst_in(rst), .clk_en_in(en),
    .power_on_in(por), .sfr_wr_in(wr), .sfr_addr_in(addr), .sfr_wdata_in(wd),
    .flash_clock_mode_bit_in(fx), .sfr_clock_mode_bit_in(sx), .rst_pin_out(pin),
    .rst_pin_oe_out(oe), .device_reset_out(drst), .timer_armed_out(armed));
  // Clock
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task check(logic seen, logic exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: value mismatch", $time);
    end
  endtask
  task complete_run;
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task step(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task wr_reg(logic [7:0] a, logic [7:0] d);
    wr = 1; addr = a; wd = d;
    step(1);
    wr = 0;
    step(1);
  endtask
  // Armed changes compared with oldest note
  always @(posedge clk) begin
    #2;
    if (mon && armed !== last) begin
      if (exp_q.size() == 0) check(armed, last);
      else check(armed, exp_q.pop_front());
      last = armed;
    end
  end
  initial begin
    void'($urandom(32'h2536));
    rst = 1;
    por = 1;
    en = 1;
    wr = 0;
    addr = 8'h00;
    wd = 8'h00;
    fx = 1;
    sx = 0;
    last = 0;
    mon = 0;
    failures = 0;
    cmp_count = 0;
    step(2);
    rst = 0;
    sx = 1'($urandom);
    step(3);
    por = 0;
    step(3);
    mon = 1;
    check(armed, 0);
    // Flash bit latched; later pin changes ignored
    fx = 0;
    sx = 0;
    wr_reg(8'hA6, 8'h1E);
    wr_reg(8'hA6, 8'h55);
    wr_reg(8'hA6, 8'hE1);
    wr_reg(8'hA6, 8'hE1);
    check(armed, 0);
    // Frozen clock enable ignores a full key
    en = 0;
    wr_reg(8'hA6, 8'h1E);
    wr_reg(8'hA6, 8'hE1);
    en = 1;
    check(armed, 0);
    wr_reg(8'hA6, 8'h1E);
    wr_reg(8'hA5, 8'($urandom));
    exp_q.push_back(1);
    wr_reg(8'hA6, 8'hE1);
    for (int i = 0; i < 20; i++) wr_reg(i[0] ? 8'hA6 : 8'($urandom), 8'($urandom));
    // Service well inside the count window
    step(600);
    wr_reg(8'hA6, 8'h1E);
    wr_reg(8'hA6, 8'hE1);
    exp_q.push_back(0);
    for (n = 0; pin !== 1'b1 && n < 99000; n++) step(1);
    check(n >= 98290 && n <= 98330, 1);
    if (n < 99000) begin
      check(oe, 1);
      check(drst, 1);
      for (n = 0; pin === 1'b1 && n < 300; n++) step(1);
      check(n == 98, 1);
      step(4);
      check(armed, 0);
    end
    complete_run;
  end
endmodule
